// file: rtl/pgm_defs.vh
// Register map and field layout of the pin-edge mask and power-good block.
// Assumes inclusion by bare name from rtl/ design files.
`ifndef PGM_DEFS_VH
`define PGM_DEFS_VH

// ---------------------------------------------------------------
// Register addresses
// ---------------------------------------------------------------
`define PGM_ADDR_EDGE_STATUS 8'h3B
`define PGM_ADDR_EDGE_MASK 8'h3C
`define PGM_ADDR_PGOOD_STATUS 8'h3D

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define PGM_MASK_RESET_ONES 8'hFF
`define PGM_MASK_RESET_ZEROS 8'h00
`define PGM_STATUS_RESET 8'h00

// ---------------------------------------------------------------
// Field positions in the mask and edge status registers
// ---------------------------------------------------------------
`define PGM_BIT_PIN5_FALL 7
`define PGM_BIT_PIN5_RISE 6
`define PGM_BIT_PIN4_FALL 5
`define PGM_BIT_PIN4_RISE 4
`define PGM_BIT_PIN3_FALL 3
`define PGM_BIT_PIN3_RISE 2
`define PGM_BIT_PIN2_FALL 1
`define PGM_BIT_PIN2_RISE 0

// Power-good status: LDO four..one at 7..4, buck four..one at 3..0
`define PGM_PG_LDO_LSB 4
`define PGM_PG_BUCK_LSB 0

`endif

// file: rtl/pgm_w1c_flags.v
// Bank of sticky flags, set by hardware and cleared by writing one.
// Assumes set pulses and write strobe are synchronous to clk.
`timescale 1ns/1ps

module pgm_w1c_flags #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Set events and software clear
  input wire [WIDTH-1:0] set_evt,
  input wire clr_we,
  input wire [WIDTH-1:0] clr_data,
  // Flag state
  output reg [WIDTH-1:0] flags_q
);

  // ---------------------------------------------------------------
  // Flag bits
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      // Set beats clear so an edge arriving with the clear is kept
      always @(posedge clk) begin
        if (rst) begin
          flags_q[i] <= 1'b0;
        end else if (set_evt[i]) begin
          flags_q[i] <= 1'b1;
        end else if (clr_we && clr_data[i]) begin
          flags_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

endmodule

// file: rtl/pgm_irq_slice.v
// Pin-edge interrupt mask, pin-edge status and power-good fall status.
// Assumes a byte-wide register port from the serial control front end.
// Assumes pin and regulator levels are already synchronous to clk.
// Assumes the factory variant strap is steady while rst is high.
`timescale 1ns/1ps
`include "pgm_defs.vh"

module pgm_irq_slice #(
  parameter NPINS = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Factory variant: one selects all-ones mask reset
  input wire mask_reset_ones,
  // Register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_rvalid_q,
  // Pin levels, pins five..two at bits 3..0
  input wire [NPINS-1:0] pin_level,
  // Regulator good and enable levels, four..one at bits 3..0
  input wire [3:0] ldo_good,
  input wire [3:0] ldo_enable,
  input wire [3:0] buck_good,
  input wire [3:0] buck_enable,
  // Interrupt from the pin-edge group
  output reg pin_irq_q
);

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] ref_a;
    begin
      hit = (a == ref_a);
    end
  endfunction

  // Full address compare, so a stray address never clears a flag
  wire wr_mask = reg_wr && hit(reg_addr, `PGM_ADDR_EDGE_MASK);
  wire wr_edge = reg_wr && hit(reg_addr, `PGM_ADDR_EDGE_STATUS);
  wire wr_pg = reg_wr && hit(reg_addr, `PGM_ADDR_PGOOD_STATUS);

  // ---------------------------------------------------------------
  // Input history for edge detection
  // ---------------------------------------------------------------
  reg [NPINS-1:0] pin_prev_q;
  reg [7:0] good_prev_q;
  reg primed_q;
  wire [7:0] good_now = {ldo_good, buck_good};
  wire [7:0] enable_now = {ldo_enable, buck_enable};

  // History is primed one cycle after reset so no false edge is seen
  // Limitation: a level pulse shorter than one clock is not seen
  always @(posedge clk) begin
    if (rst) begin
      pin_prev_q <= {NPINS{1'b0}};
      good_prev_q <= 8'h00;
      primed_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_level;
      good_prev_q <= good_now;
      primed_q <= 1'b1;
    end
  end

  // Pin edges interleaved as fall/rise pairs, pin five highest
  // Bit 2k is the rise of pin k+2, bit 2k+1 its fall
  reg [7:0] edge_evt;
  integer k;
  always @* begin
    edge_evt = 8'h00;
    for (k = 0; k < NPINS; k = k + 1) begin
      edge_evt[2*k] = primed_q & pin_level[k] & ~pin_prev_q[k];
      edge_evt[2*k+1] = primed_q & ~pin_level[k] & pin_prev_q[k];
    end
  end

  // Fall of good while enabled; turning off does not raise a flag
  wire [7:0] pg_evt = {8{primed_q}} & good_prev_q & ~good_now
                      & enable_now;

  // ---------------------------------------------------------------
  // Status registers
  // ---------------------------------------------------------------
  // Both banks share the byte layout of their registers
  localparam NFLAGS = 8;
  wire [7:0] edge_flags;
  wire [7:0] power_good_fall_status;

  // Edge bank uses the mask layout, so gating is bit for bit
  pgm_w1c_flags #(
    .WIDTH(NFLAGS)
  ) u_edge_flags (
    .clk(clk),
    .rst(rst),
    .set_evt(edge_evt),
    .clr_we(wr_edge),
    .clr_data(reg_wdata),
    .flags_q(edge_flags)
  );

  // Set wins inside the bank, so a fall during a clear is kept
  pgm_w1c_flags #(
    .WIDTH(NFLAGS)
  ) u_pg_flags (
    .clk(clk),
    .rst(rst),
    .set_evt(pg_evt),
    .clr_we(wr_pg),
    .clr_data(reg_wdata),
    .flags_q(power_good_fall_status)
  );

  // Named fall flags, LDOs in the high nibble, bucks in the low
  // Each stays set until software writes one to it
  wire ldo_four_good_fall_flag = power_good_fall_status[`PGM_PG_LDO_LSB+3];
  wire ldo_three_good_fall_flag = power_good_fall_status[`PGM_PG_LDO_LSB+2];
  wire ldo_two_good_fall_flag = power_good_fall_status[`PGM_PG_LDO_LSB+1];
  wire ldo_one_good_fall_flag = power_good_fall_status[`PGM_PG_LDO_LSB];
  wire buck_four_good_fall_flag = power_good_fall_status[`PGM_PG_BUCK_LSB+3];
  wire buck_three_good_fall_flag = power_good_fall_status[`PGM_PG_BUCK_LSB+2];
  wire buck_two_good_fall_flag = power_good_fall_status[`PGM_PG_BUCK_LSB+1];
  wire buck_one_good_fall_flag = power_good_fall_status[`PGM_PG_BUCK_LSB];

  // ---------------------------------------------------------------
  // Mask register
  // ---------------------------------------------------------------
  reg [7:0] pin_edge_irq_mask_q;
  // Writes land on the next edge; the gate sees them a cycle later
  always @(posedge clk) begin
    if (rst) begin
      // Variant strap is a level sampled by this clocked reset
      pin_edge_irq_mask_q <= mask_reset_ones ? `PGM_MASK_RESET_ONES
                                             : `PGM_MASK_RESET_ZEROS;
    end else if (wr_mask) begin
      pin_edge_irq_mask_q <= reg_wdata;
    end
  end

  // Named mask fields; a one keeps that edge off the interrupt
  // Each field sits at the same bit as its edge flag
  wire pin5_fall_mask = pin_edge_irq_mask_q[`PGM_BIT_PIN5_FALL];
  wire pin5_rise_mask = pin_edge_irq_mask_q[`PGM_BIT_PIN5_RISE];
  wire pin4_fall_mask = pin_edge_irq_mask_q[`PGM_BIT_PIN4_FALL];
  wire pin4_rise_mask = pin_edge_irq_mask_q[`PGM_BIT_PIN4_RISE];
  wire pin3_fall_mask = pin_edge_irq_mask_q[`PGM_BIT_PIN3_FALL];
  wire pin3_rise_mask = pin_edge_irq_mask_q[`PGM_BIT_PIN3_RISE];
  wire pin2_fall_mask = pin_edge_irq_mask_q[`PGM_BIT_PIN2_FALL];
  wire pin2_rise_mask = pin_edge_irq_mask_q[`PGM_BIT_PIN2_RISE];

  // ---------------------------------------------------------------
  // Interrupt gating; masked flags remain visible in status
  // ---------------------------------------------------------------
  // Any unmasked flag raises the line; it drops once the flag clears
  always @(posedge clk) begin
    if (rst) begin
      pin_irq_q <= 1'b0;
    end else begin
      pin_irq_q <= 1'b0
                 | (edge_flags[`PGM_BIT_PIN5_FALL] & ~pin5_fall_mask)
                 | (edge_flags[`PGM_BIT_PIN5_RISE] & ~pin5_rise_mask)
                 | (edge_flags[`PGM_BIT_PIN4_FALL] & ~pin4_fall_mask)
                 | (edge_flags[`PGM_BIT_PIN4_RISE] & ~pin4_rise_mask)
                 | (edge_flags[`PGM_BIT_PIN3_FALL] & ~pin3_fall_mask)
                 | (edge_flags[`PGM_BIT_PIN3_RISE] & ~pin3_rise_mask)
                 | (edge_flags[`PGM_BIT_PIN2_FALL] & ~pin2_fall_mask)
                 | (edge_flags[`PGM_BIT_PIN2_RISE] & ~pin2_rise_mask);
    end
  end

  // ---------------------------------------------------------------
  // Read path, one cycle latency; other addresses read zero
  // ---------------------------------------------------------------
  // Registered data keeps the port timing the same for every register
  // Unmapped reads return zero rather than stalling the port
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `PGM_ADDR_EDGE_STATUS: reg_rdata_q <= edge_flags;
          `PGM_ADDR_EDGE_MASK: reg_rdata_q <= pin_edge_irq_mask_q;
          `PGM_ADDR_PGOOD_STATUS: reg_rdata_q <= {ldo_four_good_fall_flag,
                                                  ldo_three_good_fall_flag,
                                                  ldo_two_good_fall_flag,
                                                  ldo_one_good_fall_flag,
                                                  buck_four_good_fall_flag,
                                                  buck_three_good_fall_flag,
                                                  buck_two_good_fall_flag,
                                                  buck_one_good_fall_flag};
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

endmodule

// file: verification/pgm_irq_slice_properties.sv
// Port-level checks for the pin-edge mask and power-good slice.
// Assumes it is bound to pgm_irq_slice.
`timescale 1ns/1ps
module pgm_irq_props #(
  parameter NPINS = 4
) (
  // Clock, reset, strap
  input logic clk,
  input logic rst,
  input logic mask_reset_ones,
  // Register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata_q,
  input logic reg_rvalid_q,
  // Pins and interrupt
  input logic [NPINS-1:0] pin_level,
  input logic pin_irq_q
);
  logic [7:0] mask_q;
  // Mask shadow, so edge checks know which edges are blocked
  always @(posedge clk)
    if (rst) mask_q <= mask_reset_ones ? 8'hFF : 8'h00;
    else if (reg_wr && reg_addr == 8'h3C) mask_q <= reg_wdata;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read not answered");
  AST_RD_ONCE: assert property (!reg_rd |=> !reg_rvalid_q)
    else $error("stray read valid");
  AST_RST_QUIET: assert property (disable iff (1'b0) rst |=>
    !pin_irq_q && !reg_rvalid_q && reg_rdata_q == 8'h00)
    else $error("outputs not quiet in reset");
  AST_MASK_RD: assert property (reg_rd && !reg_wr &&
    reg_addr == 8'h3C |=> reg_rdata_q == $past(mask_q))
    else $error("mask read mismatch");
  AST_P5_FALL: assert property (!$past(rst) &&
    !(reg_wr && reg_addr == 8'h3C) &&
    $fell(pin_level[3]) && !mask_q[7] |-> ##2 pin_irq_q)
    else $error("pin five fall gave no irq");
  AST_P4_FALL: assert property (!$past(rst) &&
    !(reg_wr && reg_addr == 8'h3C) &&
    $fell(pin_level[2]) && !mask_q[5] |-> ##2 pin_irq_q)
    else $error("pin four fall gave no irq");
  AST_P2_RISE: assert property (!$past(rst) &&
    !(reg_wr && reg_addr == 8'h3C) &&
    $rose(pin_level[0]) && !mask_q[0] |-> ##2 pin_irq_q)
    else $error("pin two rise gave no irq");
  AST_ALL_MASKED: assert property (mask_q == 8'hFF &&
    $past(mask_q) == 8'hFF |=> !pin_irq_q)
    else $error("irq while all masked");
endmodule
bind pgm_irq_slice pgm_irq_props #(.NPINS(NPINS)) i_props (.clk(clk),
  .rst(rst), .mask_reset_ones(mask_reset_ones), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .pin_level(pin_level), .pin_irq_q(pin_irq_q));

// file: verification/tb.sv
// Self-checking bench for the pin-edge mask and power-good slice.
// Assumes the bound checker is compiled with it.
`timescale 1ns/1ps
module tb;
  logic clk = 0, rst = 1, strap = 1, wr = 0, rd = 0, rvalid, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] pins = 4'h0, lg = 4'hF, le = 4'hF, bg = 4'hF, be = 4'hF;
  int err_total = 0, check_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  pgm_irq_slice #(.NPINS(4)) i_dut (.clk(clk), .rst(rst),
    .mask_reset_ones(strap), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
    .pin_level(pins), .ldo_good(lg), .ldo_enable(le), .buck_good(bg),
    .buck_enable(be), .pin_irq_q(irq));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask
  // Inputs change on the falling edge, clear of the sampling edge
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 0;
  endtask
  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd = 1;
    addr = a;
    @(negedge clk);
    rd = 0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  task t_reset(input logic s, input logic [7:0] m);
    rst = 1;
    strap = s;
    repeat (16) @(negedge clk);
    rst = 0;
    chk({7'h00, irq}, 8'h00);
    rd_reg(8'h3C, m);
    rd_reg(8'h3D, 8'h00);
  endtask
  task t_mask;
    wr_reg(8'h3C, 8'hA5);
    rd_reg(8'h3C, 8'hA5);
    wr_reg(8'h3C, 8'h5A);
    rd_reg(8'h3C, 8'h5A);
    rd_reg(8'h40, 8'h00);
  endtask
  // One mask bit open per pass; even bits rise, odd bits fall
  task t_edges;
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h3C, ~(8'h01 << i));
      pins[i/2] = ~i[0];
      repeat (3) @(negedge clk);
      chk({7'h00, irq}, 8'h01);
      rd_reg(8'h3B, 8'h01 << i);
      wr_reg(8'h3C, 8'hFF);
      repeat (2) @(negedge clk);
      chk({7'h00, irq}, 8'h00);
      rd_reg(8'h3B, 8'h01 << i);
      wr_reg(8'h3B, 8'h01 << i);
      rd_reg(8'h3B, 8'h00);
    end
  endtask
  // Disabled bucks two and four must not flag their fall
  task t_pgood;
    be = 4'h5;
    @(negedge clk);
    lg = 4'h0;
    bg = 4'h0;
    repeat (3) @(negedge clk);
    rd_reg(8'h3D, 8'hF5);
    wr_reg(8'h3D, 8'h0F);
    rd_reg(8'h3D, 8'hF0);
    wr_reg(8'h3D, 8'hF0);
    rd_reg(8'h3D, 8'h00);
  endtask
  // Edge and its write-one clear in one cycle: the edge must survive
  task t_race;
    @(negedge clk);
    wr = 1;
    addr = 8'h3B;
    wdata = 8'h01;
    pins[0] = 1'b1;
    @(negedge clk);
    wr = 0;
    rd_reg(8'h3B, 8'h01);
    pins[0] = 1'b0;
    wr_reg(8'h3B, 8'hFF);
    rd_reg(8'h3B, 8'h00);
  endtask
  task wrap_up;
    $display("mismatches %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    t_reset(1'b1, 8'hFF);
    t_mask;
    t_reset(1'b0, 8'h00);
    t_edges;
    t_pgood;
    t_race;
    wrap_up;
  end
endmodule
